//--- design/port8_regs.svh
// Register offsets, field positions and reset values of the port 8 block
// Behaviour
// - Direction register reads back as all ones
// - Reset or hardware standby loads direction 0xF0
// - Software standby keeps direction and output drive
// - Direction one on pins 4..1 drives chip selects
// - Pin 0 direction one, no refresh: latch output
// - Direction zero without other function means input
// - Data read gives latch bit where direction one
// - Data read gives pin level where direction zero
// - Data bits 7..5 unwritable, always read one
// - Reset or hardware standby loads data 0xE0
// - Software standby keeps data register contents
// - Refresh enable puts refresh strobe on pin 0
`ifndef PORT8_REGS_SVH
`define PORT8_REGS_SVH

// Register indices; the byte address is four times the index
`define P8_DIR_IDX 16'hFFCD
`define P8_DATA_IDX 16'hFFCF
`define P8_DIR_ADDR 18'h3FF34
`define P8_DATA_ADDR 18'h3FF3C

// Reset values
`define P8_DIR_RESET 8'hF0
`define P8_DATA_RESET 8'hE0

// Fixed read values and field layout
`define P8_DIR_READ 8'hFF
`define P8_RSVD_MASK 8'hE0
`define P8_PIN_MSB 4
`define P8_REFRESH_STROBE_OUT_PIN 0
`define P8_CS_LSB 1

`endif

//--- design/port8_pkg.sv
// Types shared by the port 8 block
`default_nettype none
package port8_pkg;

   // Register bus answer phase
   typedef enum logic [0:0] {
      WB_IDLE = 1'b0,
      WB_ANSWER = 1'b1
   } wb_phase_t;

   // Function chosen for a single pin
   typedef enum logic [1:0] {
      FUNC_INPUT = 2'b00,
      FUNC_PORT_OUT = 2'b01,
      FUNC_CS_OUT = 2'b10,
      FUNC_REFRESH_STROBE_OUT_OUT = 2'b11
   } pin_func_t;

   // Whole register state of the top module
   typedef struct packed {
      wb_phase_t phase;
      logic [4:0] dir;
      logic [4:0] data;
      logic [7:0] rdat;
   } port8_state_t;

endpackage
`default_nettype wire

//--- design/port8_mux_if.sv
// Signals between the port 8 registers and its pin multiplexer
`default_nettype none
interface port8_mux_if;
   logic [4:0] dir; // Direction bits
   logic [4:0] data; // Output latch bits
   logic [3:0] cs_n; // Chip selects 0..3, active low
   logic refresh_strobe_out_en; // Refresh pin enable
   logic refresh_strobe_out_n; // Refresh strobe, active low
   logic [4:0] drive; // Pin output level
   logic [4:0] drive_en; // Pin output enable

   // Register side
   modport regs (
      output dir, data, cs_n, refresh_strobe_out_en, refresh_strobe_out_n,
      input drive, drive_en
   );

   // Multiplexer side
   modport mux (
      input dir, data, cs_n, refresh_strobe_out_en, refresh_strobe_out_n,
      output drive, drive_en
   );
endinterface
`default_nettype wire

//--- design/port8_pin_mux.sv
// Pin function selection for the five port 8 pins
`include "port8_regs.svh"
`default_nettype none
module port8_pin_mux (
   // Register side
   port8_mux_if.mux m
);

   // Pins 4..1: chip select when direction is one, else input
   genvar i;
   generate
      for (i = `P8_CS_LSB; i <= `P8_PIN_MSB; i = i + 1) begin : g_cs
         port8_pkg::pin_func_t func;
         always_comb begin
            // Pin 4 carries select 0, pin 1 carries select 3
            func = m.dir[i] ? port8_pkg::FUNC_CS_OUT
                            : port8_pkg::FUNC_INPUT;
         end
         assign m.drive[i] = m.cs_n[`P8_PIN_MSB - i];
         assign m.drive_en[i] = (func == port8_pkg::FUNC_CS_OUT);
      end
   endgenerate

   // Pin 0: refresh strobe has priority over the port function
   port8_pkg::pin_func_t func0;
   always_comb begin
      if (m.refresh_strobe_out_en) begin
         func0 = port8_pkg::FUNC_REFRESH_STROBE_OUT_OUT;
      end else if (m.dir[`P8_REFRESH_STROBE_OUT_PIN]) begin
         func0 = port8_pkg::FUNC_PORT_OUT;
      end else begin
         func0 = port8_pkg::FUNC_INPUT;
      end
   end

   // Drive level and enable for pin 0, kept local so that every
   // bit of the drive vectors has one kind of driver only
   logic drive0; // Pin 0 level
   logic en0; // Pin 0 output enable
   always_comb begin
      case (func0)
         port8_pkg::FUNC_REFRESH_STROBE_OUT_OUT: begin
            drive0 = m.refresh_strobe_out_n;
            en0 = 1'b1;
         end
         port8_pkg::FUNC_PORT_OUT: begin
            drive0 = m.data[`P8_REFRESH_STROBE_OUT_PIN];
            en0 = 1'b1;
         end
         default: begin
            // Input: keep the driver off
            drive0 = 1'b0;
            en0 = 1'b0;
         end
      endcase
   end
   assign m.drive[`P8_REFRESH_STROBE_OUT_PIN] = drive0;
   assign m.drive_en[`P8_REFRESH_STROBE_OUT_PIN] = en0;

endmodule // port8_pin_mux
`default_nettype wire

//--- design/port8_io.sv
// Port 8 I/O block: registers, Wishbone slave and pin functions
//
// The Wishbone interface to the registers was decided locally.
`include "port8_regs.svh"
`default_nettype none
module port8_io #(
   parameter int ADDR_W = 18 // Wishbone byte address width
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,

   // Power state
   input wire logic hw_standby,
   input wire logic sw_standby,

   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,

   // Alternate functions from other blocks
   input wire logic chip_select_0,
   input wire logic chip_select_1,
   input wire logic chip_select_2,
   input wire logic chip_select_3,
   input wire logic refresh_pin_enable,
   input wire logic refresh_strobe_out,

   // Port pins
   input wire logic [4:0] pin_i,
   output logic [4:0] pin_o,
   output logic [4:0] pin_oe,

   // External interrupt inputs fed by the pins
   output logic ext_interrupt_in_0,
   output logic ext_interrupt_in_1,
   output logic ext_interrupt_in_2,
   output logic ext_interrupt_in_3
);

   // Register state and its next value
   port8_pkg::port8_state_t st_q;
   port8_pkg::port8_state_t st_d;

   // Reset images of the stored bits
   localparam logic [7:0] DIR_RST = `P8_DIR_RESET;
   localparam logic [7:0] DATA_RST = `P8_DATA_RESET;
   localparam logic [7:0] RSVD_ONES = `P8_RSVD_MASK;

   // Full-width address constants
   localparam logic [ADDR_W-1:0] DIR_ADDR = ADDR_W'(`P8_DIR_ADDR);
   localparam logic [ADDR_W-1:0] DATA_ADDR = ADDR_W'(`P8_DATA_ADDR);

   // Bus request qualifiers
   logic req; // Request present
   logic hit_dir; // Direction register addressed
   logic hit_data; // Data register addressed
   logic wr_lane; // Low byte lane written
   logic wr_ok; // Write may change state

   // Read value of the data register
   logic [7:0] data_view;

   // Interface to the pin multiplexer
   port8_mux_if mux_bus ();

   // Request and address decode
   always_comb begin
      req = wb_cyc_i & wb_stb_i;
      hit_dir = 1'b0;
      hit_data = 1'b0;
      if (wb_adr_i == DIR_ADDR) begin
         hit_dir = 1'b1;
      end else if (wb_adr_i == DATA_ADDR) begin
         hit_data = 1'b1;
      end else begin
         // Unmapped: answered, reads zero, writes dropped
         hit_dir = 1'b0;
      end
      wr_lane = wb_we_i & wb_sel_i[0];
      // Writes are held off in software standby, so no bus write
      // can disturb the kept values while the core sleeps
      wr_ok = wr_lane & ~sw_standby;
   end

   // Per-pin view: latch where output, live level where input
   genvar b;
   generate
      for (b = 0; b <= `P8_PIN_MSB; b = b + 1) begin : g_view
         assign data_view[b] = st_q.dir[b] ? st_q.data[b]
                                           : pin_i[b];
      end
   endgenerate

   // Reserved bits carry no storage and always read one
   assign data_view[7:5] = RSVD_ONES[7:5];

   // Next-state logic for bus phase and registers
   always_comb begin
      st_d = st_q;
      case (st_q.phase)
         port8_pkg::WB_IDLE: begin
            // Take a request, sample read data for the answer
            if (req) begin
               st_d.phase = port8_pkg::WB_ANSWER;
               if (wb_we_i) begin
                  st_d.rdat = 8'h00;
               end else if (hit_dir) begin
                  // Stored bits are never visible
                  st_d.rdat = `P8_DIR_READ;
               end else if (hit_data) begin
                  st_d.rdat = data_view;
               end else begin
                  st_d.rdat = 8'h00;
               end
            end
         end
         port8_pkg::WB_ANSWER: begin
            // Write lands at the edge that samples ack high
            st_d.phase = port8_pkg::WB_IDLE;
            if (req && wr_ok && hit_dir) begin
               st_d.dir = wb_dat_i[4:0];
            end
            if (req && wr_ok && hit_data) begin
               // Bits 4..0 take the value in any direction,
               // so an output starts from a known level
               st_d.data = wb_dat_i[4:0];
            end
         end
         default: begin
            st_d.phase = port8_pkg::WB_IDLE;
         end
      endcase

      // Hardware standby forces defaults like a reset
      if (hw_standby) begin
         st_d.dir = DIR_RST[4:0];
         st_d.data = DATA_RST[4:0];
      end
   end

   // State register; software standby holds dir and data, the bus phase still runs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q.phase <= port8_pkg::WB_IDLE;
         st_q.dir <= DIR_RST[4:0];
         st_q.data <= DATA_RST[4:0];
         st_q.rdat <= 8'h00;
      end else begin
         st_q <= st_d;
      end
   end

   // Bus answer from registered state
   assign wb_ack_o = (st_q.phase == port8_pkg::WB_ANSWER);
   assign wb_dat_o = {24'h000000, st_q.rdat};

   // Feed the multiplexer
   assign mux_bus.dir = st_q.dir;
   assign mux_bus.data = st_q.data;
   assign mux_bus.cs_n = {chip_select_3, chip_select_2,
                          chip_select_1, chip_select_0};
   assign mux_bus.refresh_strobe_out_en = refresh_pin_enable;
   assign mux_bus.refresh_strobe_out_n = refresh_strobe_out;

   // Pin function selection
   port8_pin_mux u_mux (
      .m (mux_bus.mux)
   );

   // Pin drivers; chip selects pass without a register stage
   // so that their timing follows the bus controller directly
   assign pin_o = mux_bus.drive;
   assign pin_oe = mux_bus.drive_en;

   // Interrupt inputs see the pin whatever drives it
   assign ext_interrupt_in_0 = pin_i[0];
   assign ext_interrupt_in_1 = pin_i[1];
   assign ext_interrupt_in_2 = pin_i[2];
   assign ext_interrupt_in_3 = pin_i[3];

endmodule // port8_io
`default_nettype wire

//--- dv/port8_io_properties.sv
// Checker for the port 8 bus timing and pin functions
`default_nettype none
module port8_io_properties #(parameter int ADDR_W = 18) (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and refresh function
   input wire logic refresh_pin_enable,
   input wire logic refresh_strobe_out,
   input wire logic [4:0] pin_i,
   input wire logic [4:0] pin_o,
   input wire logic [4:0] pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Request taken at this edge, reads of each register
   logic tk, rdir, rdat;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rdir = tk && !wb_we_i && wb_adr_i == 18'h3FF34;
   assign rdat = tk && !wb_we_i && wb_adr_i == 18'h3FF3C;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ack; tk |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
   a_idle: assert property (p_idle) else $error("ack unasked");
   property p_dir; rdir |=> wb_dat_o[7:0] == 8'hFF; endproperty
   a_dir: assert property (p_dir) else $error("dir read");
   property p_rsvd; rdat |=> wb_dat_o[7:5] == 3'h7; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits");
   // Pin 0 left out: its read follows direction even in refresh mode
   property p_in; rdat |=> ((wb_dat_o[4:0] ^ $past(pin_i))
      & ~$past(pin_oe) & 5'h1E) == 5'h00; endproperty
   a_in: assert property (p_in) else $error("pin level read");
   property p_rst; $fell(sys_rst) |-> pin_oe[4:1] == 4'h8; endproperty
   a_rst: assert property (p_rst) else $error("reset drive");
   property p_rf; refresh_pin_enable |->
      pin_oe[0] && pin_o[0] == refresh_strobe_out; endproperty
   a_rf: assert property (p_rf) else $error("refresh pin");
   // Main scenarios reached
   cover property (rdat);
   cover property (refresh_pin_enable && rdat);
   cover property (pin_oe == 5'h1F);
endmodule // port8_io_properties
bind port8_io port8_io_properties #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

//--- dv/port8_pin_model.sv
// Far-side peripherals that hold the port pins
`default_nettype none
module port8_pin_model (
   // Device drive and far-side level
   input wire logic [4:0] pin_o,
   input wire logic [4:0] pin_oe,
   input wire logic [4:0] ext_lvl,
   // Wire level seen by the device
   output logic [4:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven pins read their drive, others the peripheral level
   assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // port8_pin_model
`default_nettype wire

//--- dv/port8_io_tb.sv
// Self-checking bench for the port 8 block
`default_nettype none
module port8_io_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Bench drive, bus and pin signals
   logic clk = 1'b0, sys_rst = 1'b1, hws = 1'b0, sws = 1'b0, rfe = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rfs = 1'b0, ack;
   logic [17:0] adr = 18'h00000;
   logic [31:0] wd = 32'h00000000, rd;
   logic [3:0] cs = 4'h3, irq;
   logic [4:0] ext = 5'h0B, pi, po, poe;
   logic [7:0] q;
   int err_total = 0, total_checks = 0;
   localparam logic [17:0] DIR = 18'h3FF34, DAT = 18'h3FF3C;
   always #2 clk = ~clk; // 250 MHz
   port8_io u_port8_io (.clk(clk), .sys_rst(sys_rst), .hw_standby(hws),
      .sw_standby(sws), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
      .wb_ack_o(ack), .chip_select_0(cs[0]), .chip_select_1(cs[1]),
      .chip_select_2(cs[2]), .chip_select_3(cs[3]), .pin_i(pi),
      .refresh_pin_enable(rfe), .refresh_strobe_out(rfs), .pin_o(po),
      .pin_oe(poe), .ext_interrupt_in_0(irq[0]),
      .ext_interrupt_in_1(irq[1]), .ext_interrupt_in_2(irq[2]),
      .ext_interrupt_in_3(irq[3]));
   port8_pin_model u_port8_pin_model (.pin_o(po), .pin_oe(poe),
      .ext_lvl(ext), .pin_i(pi));
   task automatic bus(input logic w, input logic [17:0] a,
      input logic [7:0] d); // Held until ack is seen
      @(posedge clk);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, 24'h000000, d};
      while (ack !== 1'b1) @(posedge clk);
      q = rd[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) err_total++;
      if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
   endtask
   task summarize; // Counts, verdict, end of run
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task t_reset; // Defaults, pins 3..0 read live
      bus(0, DIR, 8'h00);
      chk("dir_read", 8'hFF, q);
      bus(0, DAT, 8'h00);
      chk("data_reset", 8'hEB, q);
      $display("t_reset done");
   endtask
   task t_out; // Latch written while pins 3..0 input, then all outputs
      bus(1, DAT, 8'h15);
      bus(1, DIR, 8'h1F);
      bus(0, DAT, 8'h00);
      chk("data_latch", 8'hF5, q);
      chk("pins_oe", 8'h1F, {3'h0, poe});
      chk("pins_out", 8'h19, {3'h0, po});
      $display("t_out done");
   endtask
   task t_stby; // Writes ignored in standby
      sws <= 1'b1;
      bus(1, DIR, 8'h00);
      bus(1, DAT, 8'h00);
      bus(0, DAT, 8'h00);
      chk("sw_keep", 8'hF5, q);
      chk("sw_oe", 8'h1F, {3'h0, poe});
      {sws, hws} <= 2'b01;
      @(posedge clk);
      hws <= 1'b0;
      bus(0, DAT, 8'h00);
      chk("hw_data", 8'hEB, q);
      $display("t_stby done");
   endtask
   task t_refresh_strobe_out; // Strobe drives pin 0 low then high while latch bit is zero
      rfe <= 1'b1;
      bus(1, DIR, 8'h00);
      bus(0, DAT, 8'h00);
      chk("refresh_strobe_out_read", 8'hEA, q);
      chk("refresh_strobe_out_pin", 8'h01, {3'h0, poe & ~po});
      chk("irq", 8'h0A, {4'h0, irq});
      rfs <= 1'b1;
      @(posedge clk);
      chk("refresh_strobe_out_level", 8'h01, {7'h00, po[0]});
      rfe <= 1'b0;
      $display("t_refresh_strobe_out done");
   endtask
   initial begin // Reset, then scenarios in turn
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_out;
      t_stby;
      t_refresh_strobe_out;
      summarize;
   end
   initial begin // Watchdog, far past the normal run
      repeat (2000) @(posedge clk);
      err_total++;
      summarize;
   end
endmodule // port8_io_tb
`default_nettype wire
